// File: bench/mmc_host_model.sv
// Host board model: makes the two-wire clock and pulls the data line.
// Assumes the bench resolves the line with a pull-up.
`default_nettype none
module mmc_host_model (
    output logic     scl,
    output logic     sdaPull,
    input wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic start();
        sdaPull = 1'b0;
        #50 scl = 1'b1;
        #100 sdaPull = 1'b1;
        #100 scl = 1'b0;
        #50;
    endtask
    task automatic stop();
        sdaPull = 1'b1;
        #50 scl = 1'b1;
        #100 sdaPull = 1'b0;
        #100;
    endtask
    task automatic bitOut(input logic b);
        sdaPull = ~b;
        #50 scl = 1'b1;
        #100 scl = 1'b0;
        #50;
    endtask
    task automatic bitIn(output logic b);
        sdaPull = 1'b0;
        #50 scl = 1'b1;
        #50 b = sdaLine;
        #50 scl = 1'b0;
        #50;
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bitOut(b[i]);
        bitIn(ack);
        ack = ~ack;
    endtask
    task automatic recvByte(output logic [7:0] b, input logic last);
        for (int i = 7; i >= 0; i--) bitIn(b[i]);
        bitOut(last);
    endtask
endmodule
`default_nettype wire

// File: bench/mmc_props.sv
// Checker of the management block's pin responses and data-line timing.
// Assumes clkEn high and host pins changing off sysClk edges.
`default_nettype none
module mmc_props #(parameter INIT_CYC = 16) (
    input wire logic sysClk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic modSelN,
    input wire logic transmitterOffRequest,
    input wire logic powerDownReset,
    input wire logic signalPresent,
    input wire logic scl,
    input wire logic sdaOe,
    input wire logic moduleAbsent,
    input wire logic moduleNotReady,
    input wire logic receiveSignalLost,
    input wire logic laserOn,
    input wire logic standby
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] waitCnt_r;
    default clocking @(posedge sysClk); endclocking
    default disable iff (!rst_n || !clkEn);
    // Cycles spent not ready
    always @(posedge sysClk)
        if (!rst_n || !moduleNotReady) waitCnt_r <= 8'h00;
        else if (waitCnt_r != 8'hff) waitCnt_r <= waitCnt_r + 8'h01;
    property p_absent; !moduleAbsent; endproperty
    a_absent: assert property (p_absent)
        else $error("absent pin high");
    property p_off; transmitterOffRequest[*5] |-> !laserOn; endproperty
    a_off: assert property (p_off)
        else $error("laser not off");
    property p_on; ($fell(transmitterOffRequest) ##1 (!transmitterOffRequest
        && !powerDownReset && !moduleNotReady)[*5]) |-> laserOn; endproperty
    a_on: assert property (p_on)
        else $error("laser not back on");
    property p_stby; powerDownReset[*5] |-> standby; endproperty
    a_stby: assert property (p_stby)
        else $error("no standby");
    property p_pdrst; $fell(powerDownReset) |-> ##[1:5] moduleNotReady;
    endproperty
    a_pdrst: assert property (p_pdrst)
        else $error("no reset on power-down fall");
    property p_early; $rose(rst_n) |-> moduleNotReady[*8]; endproperty
    a_early: assert property (p_early)
        else $error("ready too early");
    property p_ready; waitCnt_r <= INIT_CYC + 3; endproperty
    a_ready: assert property (p_ready)
        else $error("not ready too long");
    property p_los; !signalPresent[*5] |-> receiveSignalLost; endproperty
    a_los: assert property (p_los)
        else $error("loss not flagged");
    property p_sig; (signalPresent && !powerDownReset)[*8]
        |-> !receiveSignalLost; endproperty
    a_sig: assert property (p_sig)
        else $error("loss flagged with signal");
    property p_desel; modSelN[*5] |-> !sdaOe; endproperty
    a_desel: assert property (p_desel)
        else $error("data driven while deselected");
    property p_launch; $changed(sdaOe) && !moduleNotReady |-> !scl;
    endproperty
    a_launch: assert property (p_launch)
        else $error("data changed with clock high");
    c_laser: cover property (laserOn ##1 !laserOn);
    c_drive: cover property ($rose(sdaOe));
    c_pd: cover property ($fell(powerDownReset));
endmodule
bind mmc_module_mgmt mmc_props #(.INIT_CYC(INIT_CYC)) u_mmc_props (
    .sysClk(sysClk), .rst_n(rst_n), .clkEn(clkEn), .modSelN(modSelN),
    .scl(scl),
    .transmitterOffRequest(transmitterOffRequest), .sdaOe(sdaOe),
    .powerDownReset(powerDownReset), .signalPresent(signalPresent),
    .moduleAbsent(moduleAbsent), .moduleNotReady(moduleNotReady),
    .receiveSignalLost(receiveSignalLost), .laserOn(laserOn),
    .standby(standby));
`default_nettype wire

// File: bench/testbench.sv
// Bench for the management block: pins, two-wire memory, flags, resets.
// Assumes the host model runs the two-wire bus, data line pulled up.
`default_nettype none
`include "mmc_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sysClk, rst_n = 1'b0, modSelN = 1'b0, txOff = 1'b0, pd = 1'b0;
    logic sigOk = 1'b1, thrLock = 1'b0, ack, clkEn = 1'b1;
    logic [7:0] rd;
    logic [7:0] thr[$];
    logic [15:0] mon [5] = '{16'h1234, 16'h0156, 16'h0178, 16'h019a,
        16'h01bc};
    wire logic scl, sdaPull, sdaOut, sdaOe, intN, absent, notReady;
    wire logic los, laserOn, standby;
    wire logic sdaLine = !(sdaPull || (sdaOe && !sdaOut));
    int fail_count = 0, cmp_count = 0, cycles = 0;
    mmc_host_model u_mmc_host_model (.scl(scl), .sdaPull(sdaPull),
        .sdaLine(sdaLine));
    mmc_module_mgmt u_mmc_module_mgmt (
        .sysClk(sysClk), .rst_n(rst_n), .clkEn(clkEn), .modSelN(modSelN),
        .transmitterOffRequest(txOff), .powerDownReset(pd),
        .signalPresent(sigOk), .thrWriteLock(thrLock), .scl(scl),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .tempVal(mon[0]),
        .biasVal(mon[1]), .txPowVal(mon[2]), .rxPowVal(mon[3]),
        .vccVal(mon[4]), .interruptN(intN), .moduleAbsent(absent),
        .moduleNotReady(notReady), .receiveSignalLost(los),
        .laserOn(laserOn), .standby(standby));
    initial begin
        sysClk = 1'b0;
        forever #12.5 sysClk = ~sysClk;
    end
    task automatic complete_run();
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sysClk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        if (got !== exp) fail_count++;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sysClk);
        #1;
    endtask
    task automatic probe(input logic [7:0] dev);
        @(posedge sysClk);
        #5 u_mmc_host_model.start();
        u_mmc_host_model.sendByte(dev, ack);
    endtask
    task automatic memWrite(input logic [7:0] ptr, input logic [7:0] q[$]);
        probe({`MMC_DEV_ADDR, 1'b0});
        check(8'(ack), 8'h01);
        u_mmc_host_model.sendByte(ptr, ack);
        foreach (q[i]) u_mmc_host_model.sendByte(q[i], ack);
        check(8'(ack), 8'h01);
        u_mmc_host_model.stop();
    endtask
    task automatic memRead(input logic [7:0] ptr, input logic [7:0] q[$],
        input logic doCheck);
        memWrite(ptr, '{});
        u_mmc_host_model.start();
        u_mmc_host_model.sendByte({`MMC_DEV_ADDR, 1'b1}, ack);
        foreach (q[i]) begin
            u_mmc_host_model.recvByte(rd, i == q.size() - 1);
            if (doCheck) check(rd, q[i]);
        end
        u_mmc_host_model.stop();
    endtask
    initial begin
        for (int i = 0; i < 40; i++) thr.push_back(i[1] ? 8'h00 : 8'hff);
        repeat (8) @(posedge sysClk);
        rst_n <= 1'b1;
        tick(2);
        check(8'(notReady), 8'h01);
        check(8'(absent), 8'h00);
        check(8'(sdaOut), 8'h00);
        tick(`MMC_INIT_CYC + 2);
        check(8'(notReady), 8'h00);
        check(8'(laserOn), 8'h01);
        check(8'(los), 8'h00);
        txOff <= 1'b1;
        sigOk <= 1'b0;
        tick(6);
        check(8'(laserOn), 8'h00);
        check(8'(los), 8'h01);
        txOff <= 1'b0;
        sigOk <= 1'b1;
        tick(6);
        check(8'(laserOn), 8'h01);
        clkEn <= 1'b0;
        txOff <= 1'b1;
        tick(6);
        check(8'(laserOn), 8'h01);
        clkEn <= 1'b1;
        tick(6);
        check(8'(laserOn), 8'h00);
        txOff <= 1'b0;
        tick(6);
        check(8'(laserOn), 8'h01);
        memWrite(8'h00, thr);
        memRead(8'h00, thr, 1'b1);
        memRead(8'h50, '{8'h00, 8'h00, 8'h00}, 1'b0);
        memRead(8'h50, '{8'h00, 8'h00, 8'h00}, 1'b1);
        check(8'(intN), 8'h01);
        memWrite(8'h00, '{8'h10, 8'h00});
        tick(4);
        check(8'(intN), 8'h00);
        memRead(8'h50, '{8'h01, 8'h00}, 1'b1);
        memRead(8'h60, '{8'h12, 8'h34, 8'h01, 8'h56, 8'h01, 8'h78, 8'h01,
            8'h9a, 8'h01, 8'hbc}, 1'b1);
        thrLock <= 1'b1;
        memWrite(8'h02, '{8'h55});
        memWrite(8'h60, '{8'haa});
        memRead(8'h02, '{8'h00}, 1'b1);
        memRead(8'h60, '{8'h12}, 1'b1);
        modSelN <= 1'b1;
        probe({`MMC_DEV_ADDR, 1'b0});
        check(8'(ack), 8'h00);
        u_mmc_host_model.stop();
        modSelN <= 1'b0;
        probe({`MMC_DEV_ADDR ^ 7'h01, 1'b0});
        check(8'(ack), 8'h00);
        u_mmc_host_model.stop();
        pd <= 1'b1;
        tick(6);
        check(8'(standby), 8'h01);
        check(8'(laserOn), 8'h00);
        pd <= 1'b0;
        tick(6);
        check(8'(notReady), 8'h01);
        tick(`MMC_INIT_CYC + 4);
        check(8'(notReady), 8'h00);
        check(8'(standby), 8'h00);
        memRead(8'h61, '{8'h34}, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire

// File: hdl/mmc_consts.vh
// Constants of the module management and control block.
// Assumes inclusion by bare name from the files under hdl/.
`ifndef MMC_CONSTS_VH
`define MMC_CONSTS_VH

// Clock and timing
`define MMC_CLK_KHZ           40000
`define MMC_TX_SWITCH_MAX_MS  100
`define MMC_INIT_CYC          16

// Two-wire device address, arbitrary default
`define MMC_DEV_ADDR          7'h50

// Memory map, byte addresses
`define MMC_MEM_AW            7
`define MMC_THR_BASE          7'h00
`define MMC_THR_END           7'h28
`define MMC_FLAG_BASE         7'h50
`define MMC_FLAG_BYTES        7'h03
`define MMC_LIVE_BASE         7'h60
`define MMC_LIVE_BYTES        7'h0a

// Two-wire states
`define MMC_ST_IDLE           4'h0
`define MMC_ST_DEV            4'h1
`define MMC_ST_DEVACK         4'h2
`define MMC_ST_ADR            4'h3
`define MMC_ST_ADRACK         4'h4
`define MMC_ST_WR             4'h5
`define MMC_ST_WRACK          4'h6
`define MMC_ST_RD             4'h7
`define MMC_ST_RDACK          4'h8

`endif

// File: hdl/mmc_module_mgmt.v
// Management and control logic of a pluggable optical module: pin
// control, diagnostics memory over the two-wire interface, alarms.
// Assumes pins arrive asynchronous to sys_clk; monitor values come
// from logic on sys_clk. Open-drain pins are modelled as levels.
`default_nettype none
`include "mmc_consts.vh"

module mmc_module_mgmt #(
    parameter [6:0] DEV_ADDR  = `MMC_DEV_ADDR,
    parameter       MEM_DEPTH = 128,
    parameter       INIT_CYC  = `MMC_INIT_CYC
) (
    input  wire        sysClk,
    input  wire        rst_n,
    input  wire        clkEn,
    input  wire        modSelN,
    input  wire        transmitterOffRequest,
    input  wire        powerDownReset,
    input  wire        signalPresent,
    input  wire        thrWriteLock,
    input  wire        scl,
    input  wire        sdaIn,
    output wire        sdaOut,
    output reg         sdaOe,
    input  wire [15:0] tempVal,
    input  wire [15:0] biasVal,
    input  wire [15:0] txPowVal,
    input  wire [15:0] rxPowVal,
    input  wire [15:0] vccVal,
    output reg         interruptN,
    output wire        moduleAbsent,
    output reg         moduleNotReady,
    output reg         receiveSignalLost,
    output reg         laserOn,
    output reg         standby
);

    localparam AW = `MMC_MEM_AW;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and full reset

    wire [5:0] pinSync;
    wire       sclS   = pinSync[0];
    wire       sdaS   = pinSync[1];
    wire       sigS   = pinSync[2];
    wire       selNS  = pinSync[3];
    wire       txOffS = pinSync[4];
    wire       pdS    = pinSync[5];

    // Pins that idle high
    mmc_sync #(.WIDTH(3), .RST_VAL(1'b1)) uSyncHi (
        .sysClk  (sysClk),
        .rstN    (rst_n),
        .clkEn   (clkEn),
        .asyncIn ({signalPresent, sdaIn, scl}),
        .syncOut (pinSync[2:0])
    );

    // Pins that idle low, so no false power-down edge follows reset
    mmc_sync #(.WIDTH(3), .RST_VAL(1'b0)) uSyncLo (
        .sysClk  (sysClk),
        .rstN    (rst_n),
        .clkEn   (clkEn),
        .asyncIn ({powerDownReset, transmitterOffRequest, modSelN}),
        .syncOut (pinSync[5:3])
    );

    reg  sclD_r;
    reg  sdaD_r;
    reg  pdD_r;
    wire sclRise = sclS & ~sclD_r;
    wire sclFall = ~sclS & sclD_r;
    wire startC  = sclS & sclD_r & sdaD_r & ~sdaS;
    wire stopC   = sclS & sclD_r & ~sdaD_r & sdaS;
    wire pdFall  = pdD_r & ~pdS;
    wire rstAll  = ~rst_n | pdFall;

    always @(posedge sysClk) begin
        if (!rst_n) begin
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
            pdD_r  <= 1'b0;
        end else if (clkEn) begin
            sclD_r <= sclS;
            sdaD_r <= sdaS;
            pdD_r  <= pdS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin control: laser, standby, loss of signal, not ready

    reg [15:0] initCnt_r;
    assign moduleAbsent = 1'b0;
    assign sdaOut       = 1'b0;

    always @(posedge sysClk) begin
        if (rstAll) begin
            initCnt_r         <= 16'h0000;
            moduleNotReady    <= 1'b1;
            laserOn           <= 1'b0;
            standby           <= 1'b0;
            receiveSignalLost <= 1'b1;
        end else if (clkEn) begin
            if (initCnt_r != INIT_CYC[15:0])
                initCnt_r <= initCnt_r + 16'h0001;
            moduleNotReady    <= (initCnt_r != INIT_CYC[15:0]);
            standby           <= pdS;
            laserOn           <= ~txOffS & ~pdS;
            receiveSignalLost <= ~sigS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Diagnostics memory, live values and range flags

    reg  [7:0]  mem [0:MEM_DEPTH-1];
    wire [79:0] liveVec = {tempVal, biasVal, txPowVal, rxPowVal, vccVal};
    wire [19:0] rangeFlags;
    reg  [23:0] sticky_r;

    function [15:0] thrWord;
        input integer idx;
        begin
            thrWord = {mem[idx], mem[idx + 1]};
        end
    endfunction

    genvar p;
    generate
        for (p = 0; p < 5; p = p + 1) begin : gMon
            wire [15:0] val = liveVec[79 - 16 * p -: 16];
            assign rangeFlags[4 * p + 0] = val > thrWord(8 * p + 0);
            assign rangeFlags[4 * p + 1] = val < thrWord(8 * p + 2);
            assign rangeFlags[4 * p + 2] = val > thrWord(8 * p + 4);
            assign rangeFlags[4 * p + 3] = val < thrWord(8 * p + 6);
        end
    endgenerate

    reg  [AW-1:0] ptr_r;
    reg  [7:0]    rdByte;
    wire [AW-1:0] flagOff = ptr_r - `MMC_FLAG_BASE;
    wire [AW-1:0] liveOff = ptr_r - `MMC_LIVE_BASE;
    wire          inFlag  = ptr_r >= `MMC_FLAG_BASE &&
                            flagOff < `MMC_FLAG_BYTES;
    wire          inLive  = ptr_r >= `MMC_LIVE_BASE &&
                            liveOff < `MMC_LIVE_BYTES;
    wire          inThr   = ptr_r < `MMC_THR_END;
    wire          canWrite = ~inFlag & ~inLive & ~(inThr & thrWriteLock);

    always @* begin
        rdByte = mem[ptr_r];
        if (inFlag)
            rdByte = sticky_r[8 * flagOff[1:0] +: 8];
        else if (inLive)
            rdByte = liveVec[79 - 8 * liveOff[3:0] -: 8];
    end

    ////////////////////////////////////////////////////////////////////
    // Two-wire slave

    reg [3:0] state_r;
    reg [2:0] bitCnt_r;
    reg [7:0] shReg_r;
    reg       ackPh_r;
    reg       rnw_r;
    reg       rdMore_r;
    reg       loadRd;
    reg       clrFlag;

    always @* begin
        loadRd = 1'b0;
        if (sclFall && (state_r == `MMC_ST_DEVACK) && ackPh_r && rnw_r)
            loadRd = 1'b1;
        if (sclFall && (state_r == `MMC_ST_RDACK) && rdMore_r)
            loadRd = 1'b1;
        clrFlag = loadRd & inFlag;
    end

    always @(posedge sysClk) begin
        if (rstAll) begin
            sticky_r <= 24'h000000;
        end else if (clkEn) begin
            // A flag raised in the read cycle survives the clear
            sticky_r <= sticky_r & ~({16'h0000, {8{clrFlag}}}
                        << (8 * flagOff[1:0])) | {4'h0, rangeFlags};
            interruptN <= ~(|sticky_r);
        end
    end

    always @(posedge sysClk) begin
        if (clkEn && state_r == `MMC_ST_WR && sclRise && selNS == 1'b0 &&
            bitCnt_r == 3'h7 && canWrite)
            mem[ptr_r] <= {shReg_r[6:0], sdaS};
    end

    always @(posedge sysClk) begin
        if (rstAll) begin
            state_r  <= `MMC_ST_IDLE;
            bitCnt_r <= 3'h0;
            shReg_r  <= 8'h00;
            ackPh_r  <= 1'b0;
            rnw_r    <= 1'b0;
            rdMore_r <= 1'b0;
            ptr_r    <= {AW{1'b0}};
            sdaOe    <= 1'b0;
        end else if (clkEn) begin
            if (selNS || stopC) begin
                state_r <= `MMC_ST_IDLE;
                sdaOe   <= 1'b0;
            end else if (startC) begin
                state_r  <= `MMC_ST_DEV;
                bitCnt_r <= 3'h0;
                sdaOe    <= 1'b0;
            end else if (loadRd) begin
                state_r  <= `MMC_ST_RD;
                sdaOe    <= ~rdByte[7];
                shReg_r  <= {rdByte[6:0], 1'b0};
                bitCnt_r <= 3'h1;
                ackPh_r  <= 1'b0;
                ptr_r    <= ptr_r + 1'b1;
            end else if (sclRise) begin
                case (state_r)
                    `MMC_ST_DEV, `MMC_ST_ADR, `MMC_ST_WR: begin
                        shReg_r  <= {shReg_r[6:0], sdaS};
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7) begin
                            case (state_r)
                                `MMC_ST_DEV: begin
                                    rnw_r <= sdaS;
                                    state_r <= (shReg_r[6:0] == DEV_ADDR) ?
                                        `MMC_ST_DEVACK : `MMC_ST_IDLE;
                                end
                                `MMC_ST_ADR: begin
                                    ptr_r   <= {shReg_r[AW-2:0], sdaS};
                                    state_r <= `MMC_ST_ADRACK;
                                end
                                default: begin
                                    ptr_r   <= ptr_r + 1'b1;
                                    state_r <= `MMC_ST_WRACK;
                                end
                            endcase
                        end
                    end
                    `MMC_ST_RDACK: begin
                        rdMore_r <= ~sdaS;
                        if (sdaS)
                            state_r <= `MMC_ST_IDLE;
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end else if (sclFall) begin
                case (state_r)
                    `MMC_ST_DEVACK, `MMC_ST_ADRACK, `MMC_ST_WRACK: begin
                        ackPh_r  <= ~ackPh_r;
                        sdaOe    <= ~ackPh_r;
                        bitCnt_r <= 3'h0;
                        if (ackPh_r)
                            state_r <= (state_r == `MMC_ST_DEVACK) ?
                                `MMC_ST_ADR : `MMC_ST_WR;
                    end
                    `MMC_ST_RD: begin
                        if (bitCnt_r == 3'h0) begin
                            sdaOe    <= 1'b0;
                            rdMore_r <= 1'b0;
                            state_r  <= `MMC_ST_RDACK;
                        end else begin
                            sdaOe    <= ~shReg_r[7];
                            shReg_r  <= {shReg_r[6:0], 1'b0};
                            bitCnt_r <= bitCnt_r + 3'h1;
                        end
                    end
                    default: begin
                        state_r <= state_r;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: hdl/mmc_sync.v
// Two-flop synchronisers for a group of pins.
// Assumes sys_clk domain, synchronous active-low reset.
`default_nettype none

module mmc_sync #(
    parameter WIDTH   = 1,
    parameter RST_VAL = 1'b0
) (
    input  wire             sysClk,
    input  wire             rstN,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gSync
            reg stage1_r;
            reg stage2_r;
            always @(posedge sysClk) begin
                if (!rstN) begin
                    stage1_r <= RST_VAL;
                    stage2_r <= RST_VAL;
                end else if (clkEn) begin
                    stage1_r <= asyncIn[i];
                    stage2_r <= stage1_r;
                end
            end
            assign syncOut[i] = stage2_r;
        end
    endgenerate

endmodule

`default_nettype wire
